// ==== logic/o1cfg_consts.svh ====
/*
 constants for the first output channel configuration bank: offsets, field
 positions, reset values. assumes an 8-bit register space with 8-bit addresses.
*/
`ifndef O1CFG_CONSTS_SVH
`define O1CFG_CONSTS_SVH
`define O1CFG_ADDR_SRC_ROUTE 8'h64
`define O1CFG_ADDR_DRIVE_LVL 8'h65
`define O1CFG_RST_SRC_ROUTE 8'h20
`define O1CFG_RST_DRIVE_LVL 8'h20
`define O1CFG_SRC_HI 7
`define O1CFG_SRC_LO 5
`define O1CFG_ROUTE_HI 4
`define O1CFG_ROUTE_LO 2
`define O1CFG_COMMON_MODE_LEVEL_BIT 1
`define O1CFG_DRIVE_HI 7
`define O1CFG_DRIVE_LO 6
`define O1CFG_LVL_HI 5
`define O1CFG_LVL_LO 3
`define O1CFG_IMP_BIT 2
`define O1CFG_INTYPE_BIT 1
`define O1CFG_BW_BIT 0
`define O1CFG_SRC_WMASK 8'hFE
`endif

// ==== logic/o1cfg_pkg.sv ====
/*
 types for the first output channel configuration bank.
 assumes o1cfg_consts.svh is included by users needing the numbers.
*/
package o1cfg_pkg;
    typedef enum logic [2:0] {
        O1CFG_SRC_RSVD0 = 3'h0,
        O1CFG_SRC_DAC = 3'h1,
        O1CFG_SRC_BYPASS = 3'h2,
        O1CFG_SRC_MIX = 3'h3,
        O1CFG_SRC_DAC_P_BYP_N = 3'h4,
        O1CFG_SRC_BYP_P_DAC_N = 3'h5,
        O1CFG_SRC_RSVD6 = 3'h6,
        O1CFG_SRC_RSVD7 = 3'h7
    } o1cfg_src_t;
    typedef enum logic [2:0] {
        O1CFG_RT_DIFF = 3'h0,
        O1CFG_RT_STEREO_SE = 3'h1,
        O1CFG_RT_MONO_P = 3'h2,
        O1CFG_RT_MONO_N = 3'h3,
        O1CFG_RT_PDIFF_NCM = 3'h4,
        O1CFG_RT_PDIFF_NCM_SNS = 3'h5,
        O1CFG_RT_PDIFF_PCM = 3'h6,
        O1CFG_RT_RSVD7 = 3'h7
    } o1cfg_route_t;
endpackage

// ==== logic/o1cfg_regfile.sv ====
/*
 two-word register store with registered read data.
 assumes one writer and one reader port on the same clock.
*/
`timescale 1ns/1ns
module o1cfg_regfile
    import o1cfg_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST0 = 8'h20,
    parameter logic [WIDTH-1:0] RST1 = 8'h20
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_in,
    input wire logic wsel_in,
    input wire logic [WIDTH-1:0] wdata_in,
    input wire logic rd_in,
    input wire logic rsel_in,
    input wire logic rhit_in,
    output logic [WIDTH-1:0] rdata_out,
    output logic [WIDTH-1:0] word0_out,
    output logic [WIDTH-1:0] word1_out
);
    logic [WIDTH-1:0] mem_q [2];

    // storage, reset to power-on values
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mem_q[0] <= RST0;
            mem_q[1] <= RST1;
        end
        else if (wr_in)
        begin
            mem_q[wsel_in] <= wdata_in;
        end
    end

    // registered read, zero when unmapped or idle
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_out <= '0;
        else if (rd_in && rhit_in)
            rdata_out <= mem_q[rsel_in];
        else
            rdata_out <= '0;
    end

    assign word0_out = mem_q[0];
    assign word1_out = mem_q[1];
endmodule

// ==== logic/o1cfg_regs.sv ====
/*
 configuration bank for the first output channel pair: source, routing,
 common mode, drive, level, bypass input and dac bandwidth fields.
 assumes a plain register port on CLOCK_IN; analog logic reads the field outputs.
*/
// The plain strobed port is this design's own decision.
// How it works
// - first register at 0x64, resets 0x20
// - second register at 0x65, resets 0x20
// - source field bits 7-5, reset 001b
// - codes 4/5 cross dac and bypass paths
// - routing field holds seven topologies, 7 reserved
// - bit 1 picks reference fraction or half supply
// - first register bit 0 reads zero
// - positive drive bits 7-6, reset zero
// - positive level bits 5-3, reset code 4
// - bit 2 selects negative bypass impedance
// - bit 1 selects bypass input type
// - bit 0 selects dac bandwidth
`timescale 1ns/1ns
`include "o1cfg_consts.svh"
module o1cfg_regs
    import o1cfg_pkg::*;
(
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    output logic [2:0] OUTPUT1_SOURCE_SELECT_OUT,
    output logic [2:0] OUTPUT1_ROUTING_SELECT_OUT,
    output logic OUTPUT1_COMMON_MODE_SELECT_OUT,
    output logic [1:0] OUTPUT1_POS_DRIVE_SELECT_OUT,
    output logic [2:0] OUTPUT1_POS_LEVEL_SELECT_OUT,
    output logic BYPASS_NEG_INPUT_IMPEDANCE_OUT,
    output logic BYPASS_INPUT_TYPE_OUT,
    output logic DAC_FIRST_BANDWIDTH_SELECT_OUT,
    output logic POS_GETS_DAC_OUT,
    output logic POS_GETS_BYPASS_OUT,
    output logic NEG_GETS_DAC_OUT,
    output logic NEG_GETS_BYPASS_OUT,
    output logic ROUTING_IN_USE_OUT
);
    logic wr0;
    logic wr1;
    logic [2:0] src_q;
    logic [2:0] route_q;
    logic common_mode_level_q;
    logic [1:0] drive_q;
    logic [2:0] level_q;
    logic imp_q;
    logic intype_q;
    logic bw_q;
    logic wsel;
    logic whit;
    logic rsel;
    logic rhit;
    logic [7:0] wmask;
    logic [7:0] wdata_d;
    logic [2:0] src;
    logic [1:0] pos_path_d;
    logic [1:0] neg_path_d;
    logic pos_dac_q;
    logic pos_byp_q;
    logic neg_dac_q;
    logic neg_byp_q;
    logic route_use_q;

    // power-on images of the two words
    localparam logic [7:0] RST0 = `O1CFG_RST_SRC_ROUTE;
    localparam logic [7:0] RST1 = `O1CFG_RST_DRIVE_LVL;

    // address decode: 1 when address names a bank register
    function automatic logic o1cfg_hit(input logic [7:0] a);
        return (a == `O1CFG_ADDR_SRC_ROUTE) || (a == `O1CFG_ADDR_DRIVE_LVL);
    endfunction

    assign whit = o1cfg_hit(ADDR_IN);
    assign wsel = (ADDR_IN == `O1CFG_ADDR_DRIVE_LVL);
    assign rhit = o1cfg_hit(ADDR_IN);
    assign rsel = (ADDR_IN == `O1CFG_ADDR_DRIVE_LVL);

    // per-word write enables, unmapped writes dropped
    assign wr0 = WR_IN && whit && !wsel;
    assign wr1 = WR_IN && whit && wsel;

    // reserved bit 0 of first word stays zero
    assign wmask = wsel ? 8'hFF : `O1CFG_SRC_WMASK;
    assign wdata_d = WDATA_IN & wmask;

    o1cfg_regfile #(
        .WIDTH(8),
        .RST0(`O1CFG_RST_SRC_ROUTE),
        .RST1(`O1CFG_RST_DRIVE_LVL)
    ) u_store (
        .clk_in(CLOCK_IN),
        .rst_in(RESET_IN),
        .wr_in(WR_IN && whit),
        .wsel_in(wsel),
        .wdata_in(wdata_d),
        .rd_in(RD_IN),
        .rsel_in(rsel),
        .rhit_in(rhit),
        .rdata_out(RDATA_OUT),
        .word0_out(),
        .word1_out()
    );

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            src_q <= RST0[`O1CFG_SRC_HI:`O1CFG_SRC_LO];
        end
        else if (wr0)
        begin
            src_q <= wdata_d[`O1CFG_SRC_HI:`O1CFG_SRC_LO];
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            route_q <= RST0[`O1CFG_ROUTE_HI:`O1CFG_ROUTE_LO];
        end
        else if (wr0)
        begin
            route_q <= wdata_d[`O1CFG_ROUTE_HI:`O1CFG_ROUTE_LO];
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            common_mode_level_q <= RST0[`O1CFG_COMMON_MODE_LEVEL_BIT];
        end
        else if (wr0)
        begin
            common_mode_level_q <= wdata_d[`O1CFG_COMMON_MODE_LEVEL_BIT];
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            drive_q <= RST1[`O1CFG_DRIVE_HI:`O1CFG_DRIVE_LO];
        end
        else if (wr1)
        begin
            drive_q <= wdata_d[`O1CFG_DRIVE_HI:`O1CFG_DRIVE_LO];
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            level_q <= RST1[`O1CFG_LVL_HI:`O1CFG_LVL_LO];
        end
        else if (wr1)
        begin
            level_q <= wdata_d[`O1CFG_LVL_HI:`O1CFG_LVL_LO];
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            imp_q <= RST1[`O1CFG_IMP_BIT];
        end
        else if (wr1)
        begin
            imp_q <= wdata_d[`O1CFG_IMP_BIT];
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            intype_q <= RST1[`O1CFG_INTYPE_BIT];
        end
        else if (wr1)
        begin
            intype_q <= wdata_d[`O1CFG_INTYPE_BIT];
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            bw_q <= RST1[`O1CFG_BW_BIT];
        end
        else if (wr1)
        begin
            bw_q <= wdata_d[`O1CFG_BW_BIT];
        end
    end

    // field outputs straight from their flip-flops
    assign OUTPUT1_SOURCE_SELECT_OUT = src_q;
    assign OUTPUT1_ROUTING_SELECT_OUT = route_q;
    assign OUTPUT1_COMMON_MODE_SELECT_OUT = common_mode_level_q;
    assign OUTPUT1_POS_DRIVE_SELECT_OUT = drive_q;
    assign OUTPUT1_POS_LEVEL_SELECT_OUT = level_q;
    assign BYPASS_NEG_INPUT_IMPEDANCE_OUT = imp_q;
    assign BYPASS_INPUT_TYPE_OUT = intype_q;
    assign DAC_FIRST_BANDWIDTH_SELECT_OUT = bw_q;

    // path steering from the next source code, so flags track the store
    assign src = wr0 ? wdata_d[`O1CFG_SRC_HI:`O1CFG_SRC_LO] : src_q;

    // independent modes cross the two paths; {dac, bypass}
    always_comb
    begin
        case (o1cfg_src_t'(src))
            O1CFG_SRC_DAC:
            begin
                pos_path_d = 2'b10;
                neg_path_d = 2'b10;
            end
            O1CFG_SRC_BYPASS:
            begin
                pos_path_d = 2'b01;
                neg_path_d = 2'b01;
            end
            O1CFG_SRC_MIX:
            begin
                pos_path_d = 2'b11;
                neg_path_d = 2'b11;
            end
            O1CFG_SRC_DAC_P_BYP_N:
            begin
                pos_path_d = 2'b10;
                neg_path_d = 2'b01;
            end
            O1CFG_SRC_BYP_P_DAC_N:
            begin
                pos_path_d = 2'b01;
                neg_path_d = 2'b10;
            end
            default:
            begin
                pos_path_d = 2'b00;
                neg_path_d = 2'b00;
            end
        endcase
    end

    // registered path flags
    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            pos_dac_q <= 1'b1;
            pos_byp_q <= 1'b0;
            neg_dac_q <= 1'b1;
            neg_byp_q <= 1'b0;
        end
        else
        begin
            pos_dac_q <= pos_path_d[1];
            pos_byp_q <= pos_path_d[0];
            neg_dac_q <= neg_path_d[1];
            neg_byp_q <= neg_path_d[0];
        end
    end

    // routing field unused in independent modes
    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
            route_use_q <= 1'b1;
        else
            route_use_q <= !(o1cfg_src_t'(src) inside {O1CFG_SRC_DAC_P_BYP_N, O1CFG_SRC_BYP_P_DAC_N});
    end

    assign POS_GETS_DAC_OUT = pos_dac_q;
    assign POS_GETS_BYPASS_OUT = pos_byp_q;
    assign NEG_GETS_DAC_OUT = neg_dac_q;
    assign NEG_GETS_BYPASS_OUT = neg_byp_q;
    assign ROUTING_IN_USE_OUT = route_use_q;
endmodule

// ==== tb/o1cfg_regs_props.sv ====
/*
 checker for the first output channel configuration bank.
 assumes it is bound onto o1cfg_regs and sees one clock domain.
*/
`timescale 1ns/1ns
module o1cfg_props (
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic [2:0] OUTPUT1_SOURCE_SELECT_OUT,
    input wire logic [2:0] OUTPUT1_ROUTING_SELECT_OUT,
    input wire logic OUTPUT1_COMMON_MODE_SELECT_OUT,
    input wire logic [1:0] OUTPUT1_POS_DRIVE_SELECT_OUT,
    input wire logic [2:0] OUTPUT1_POS_LEVEL_SELECT_OUT,
    input wire logic BYPASS_NEG_INPUT_IMPEDANCE_OUT,
    input wire logic BYPASS_INPUT_TYPE_OUT,
    input wire logic DAC_FIRST_BANDWIDTH_SELECT_OUT,
    input wire logic POS_GETS_DAC_OUT,
    input wire logic POS_GETS_BYPASS_OUT,
    input wire logic NEG_GETS_DAC_OUT,
    input wire logic NEG_GETS_BYPASS_OUT,
    input wire logic ROUTING_IN_USE_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);
    // register images rebuilt from the field outputs
    wire logic [7:0] img0 = {OUTPUT1_SOURCE_SELECT_OUT, OUTPUT1_ROUTING_SELECT_OUT,
        OUTPUT1_COMMON_MODE_SELECT_OUT, 1'b0};
    wire logic [7:0] img1 = {OUTPUT1_POS_DRIVE_SELECT_OUT, OUTPUT1_POS_LEVEL_SELECT_OUT,
        BYPASS_NEG_INPUT_IMPEDANCE_OUT, BYPASS_INPUT_TYPE_OUT, DAC_FIRST_BANDWIDTH_SELECT_OUT};
    wire logic [4:0] flg = {POS_GETS_DAC_OUT, POS_GETS_BYPASS_OUT, NEG_GETS_DAC_OUT,
        NEG_GETS_BYPASS_OUT, ROUTING_IN_USE_OUT};
    a_read_first: assert property
        (RD_IN && ADDR_IN == 8'h64 |=> RDATA_OUT == img0) else $error("first read wrong");
    a_read_second: assert property
        (RD_IN && ADDR_IN == 8'h65 |=> RDATA_OUT == img1) else $error("second read wrong");
    a_read_idle_zero: assert property
        (!RD_IN |=> RDATA_OUT == 8'h00) else $error("read data not cleared");
    a_read_unmapped: assert property
        (RD_IN && !(ADDR_IN inside {8'h64, 8'h65}) |=> RDATA_OUT == 8'h00) else $error("unmapped read");
    a_write_first: assert property
        (WR_IN && ADDR_IN == 8'h64 |=> img0 == ($past(WDATA_IN) & 8'hFE)) else $error("first write lost");
    a_write_second: assert property
        (WR_IN && ADDR_IN == 8'h65 |=> img1 == $past(WDATA_IN)) else $error("second write lost");
    a_fields_hold: assert property
        (!WR_IN |=> $stable(img0) && $stable(img1)) else $error("fields moved without write");
    a_path_dac_byp: assert property
        (OUTPUT1_SOURCE_SELECT_OUT == 3'h4 |-> flg == 5'h12) else $error("code four paths");
    a_path_byp_dac: assert property
        (OUTPUT1_SOURCE_SELECT_OUT == 3'h5 |-> flg == 5'h0C) else $error("code five paths");
    c_write_first: cover property (WR_IN && ADDR_IN == 8'h64);
    c_read_second: cover property (RD_IN && ADDR_IN == 8'h65);
    c_src_five: cover property (OUTPUT1_SOURCE_SELECT_OUT == 3'h5);
endmodule
bind o1cfg_regs o1cfg_props o1cfg_props_inst (.*);

// ==== tb/o1cfg_regs_tb.sv ====
/*
 self-checking bench for the first output channel configuration bank.
 assumes the bank alone on one clock, driven only by this bench.
*/
`timescale 1ns/1ns
module o1cfg_regs_tb;
    logic CLOCK_IN = 0, RESET_IN = 1, WR_IN = 0, RD_IN = 0;
    logic [7:0] ADDR_IN = 0, WDATA_IN = 0, RDATA_OUT;
    logic [2:0] OUTPUT1_SOURCE_SELECT_OUT, OUTPUT1_ROUTING_SELECT_OUT, OUTPUT1_POS_LEVEL_SELECT_OUT;
    logic [1:0] OUTPUT1_POS_DRIVE_SELECT_OUT;
    logic OUTPUT1_COMMON_MODE_SELECT_OUT, BYPASS_NEG_INPUT_IMPEDANCE_OUT, BYPASS_INPUT_TYPE_OUT;
    logic DAC_FIRST_BANDWIDTH_SELECT_OUT, POS_GETS_DAC_OUT, POS_GETS_BYPASS_OUT, NEG_GETS_DAC_OUT;
    logic NEG_GETS_BYPASS_OUT, ROUTING_IN_USE_OUT;
    logic [7:0] m0 = 8'h20, m1 = 8'h20;
    logic [31:0] rng = 32'h0001_1C52;
    int mismatches = 0, tests_run = 0;
    o1cfg_regs o1cfg_regs_inst (.*);
    // free-running clock
    initial forever #50 CLOCK_IN = ~CLOCK_IN;
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected {pos dac, pos byp, neg dac, neg byp, routing in use}
    function logic [4:0] paths(input logic [2:0] s);
        case (s)
            3'h1: return 5'h15;
            3'h2: return 5'h0B;
            3'h3: return 5'h1F;
            3'h4: return 5'h12;
            3'h5: return 5'h0C;
            default: return 5'h01;
        endcase
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // one strobe cycle, then model update and compares
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        WR_IN <= w;
        RD_IN <= !w;
        ADDR_IN <= a;
        WDATA_IN <= d;
        @(posedge CLOCK_IN);
        #1;
        if (w && a == 8'h64) m0 = d & 8'hFE;
        if (w && a == 8'h65) m1 = d;
        chk(RDATA_OUT, w ? 8'h00 : a == 8'h64 ? m0 : a == 8'h65 ? m1 : 8'h00);
        chk({OUTPUT1_SOURCE_SELECT_OUT, OUTPUT1_ROUTING_SELECT_OUT, OUTPUT1_COMMON_MODE_SELECT_OUT, 1'b0},
            m0);
        chk({OUTPUT1_POS_DRIVE_SELECT_OUT, OUTPUT1_POS_LEVEL_SELECT_OUT, BYPASS_NEG_INPUT_IMPEDANCE_OUT,
            BYPASS_INPUT_TYPE_OUT, DAC_FIRST_BANDWIDTH_SELECT_OUT}, m1);
        chk({3'h0, POS_GETS_DAC_OUT, POS_GETS_BYPASS_OUT, NEG_GETS_DAC_OUT, NEG_GETS_BYPASS_OUT,
            ROUTING_IN_USE_OUT}, {3'h0, paths(m0[7:5])});
    endtask
    task idle;
        WR_IN <= 0;
        RD_IN <= 0;
        @(posedge CLOCK_IN);
        #1;
        chk(RDATA_OUT, 8'h00);
    endtask
    task do_reset;
        RESET_IN <= 1;
        repeat (20) @(posedge CLOCK_IN);
        RESET_IN <= 0;
        m0 = 8'h20;
        m1 = 8'h20;
        #1;
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog, about thirteen times the expected run
    initial
    begin
        #(2000 * 100);
        mismatches++;
        print_verdict();
    end
    initial
    begin
        do_reset();
        // reset values, then an unmapped write and read
        bus(0, 8'h64, 0);
        bus(0, 8'h65, 0);
        bus(1, 8'h66, 8'hFF);
        bus(0, 8'h66, 0);
        bus(0, 8'h64, 0);
        idle();
        $display("reset and unmapped test done");
        // every source, routing, drive and level code, reserved ones included
        for (int i = 0; i < 8; i++)
        begin
            bus(1, 8'h64, {i[2:0], i[2:0], i[0], 1'b1});
            bus(1, 8'h65, {i[1:0], i[2:0], i[2:0]});
            bus(0, 8'h64, 0);
            bus(0, 8'h65, 0);
        end
        idle();
        $display("code sweep test done");
        // random mixed traffic, mostly to the two mapped words
        for (int i = 0; i < 60; i++)
        begin
            rng = lfsr(rng);
            bus(rng[0], rng[2:1] == 0 ? rng[15:8] : {7'h32, rng[1]}, rng[31:24]);
        end
        idle();
        $display("random traffic test done");
        // level codes only beside the source modes that allow them
        bus(1, 8'h64, 8'h40); // bypass only source
        bus(1, 8'h65, 8'h10); // +12 dB level
        bus(1, 8'h64, 8'h60); // mixed source
        bus(1, 8'h65, 8'h18); // +6 dB level
        bus(1, 8'h65, 8'h30); // 12 dB, low impedance
        bus(1, 8'h64, 8'h84); // code 4, routing flagged unused
        bus(0, 8'h65, 0); // level read back
        idle();
        $display("level usage test done");
        do_reset();
        bus(0, 8'h64, 0);
        bus(0, 8'h65, 0);
        idle();
        $display("second reset test done");
        print_verdict();
    end
endmodule
